// ===== rtl/adc_ctrl_pkg.sv
// Package for the converter control and read interface.
// Assumes a single 50 MHz ref_clk domain; all pins synchronised in the core.
package adc_ctrl_pkg;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int RESULT_W = 12;                  // Result bus width
    localparam int CONV_PERIODS = 13;              // Clock periods per conversion
    localparam int CLK_PERIOD_NS = 20;             // ref_clk period
    localparam int INT_DONE_MAX_NS = 900;          // Internal mode done deadline
    localparam int INT_DONE_MAX_CYC = INT_DONE_MAX_NS / CLK_PERIOD_NS; // Rounds down
    localparam int INT_DIV = 3;                    // ref_clk cycles per internal period
    localparam int SYNC_STAGES = 3;                // Pin synchroniser depth

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000; // Latched result at reset
    localparam logic [11:0] MID_CODE = 12'h800;    // Offset binary midscale / sign flip

    // Pin bundle from the host
    typedef struct packed {
        logic conv_start;      // Conversion start strobe
        logic sel_n;           // Device select
        logic rd_n;            // Read strobe
        logic ext_clk;         // External conversion clock
        logic clk_src_int;     // Clock source select, 1 = internal
        logic power_down;      // Power-down request
    } host_pins_t;

    // Done flag pair
    typedef struct packed {
        logic conv_done_n;            // Conversion done
        logic last_conversion_done_n; // Last conversion done
    } done_flags_t;

endpackage

// ===== rtl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes async input; output changes once stages two and three agree.
module pin_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Pin in, clean level out
    input wire logic pin,
    output logic level
);
    // Shift stages; stage 0 is read only by stage 1
    logic [adc_ctrl_pkg::SYNC_STAGES-1:0] sh_q;

    // ------------------------------------------------------------
    // Synchroniser chain
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sh_q <= {adc_ctrl_pkg::SYNC_STAGES{RST_VAL}};
        end else begin
            sh_q <= {sh_q[adc_ctrl_pkg::SYNC_STAGES-2:0], pin};
        end
    end

    // Agreement filter: hold until stages two and three match
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            level <= RST_VAL;
        end else if (sh_q[1] == sh_q[2]) begin
            level <= sh_q[2];
        end
    end
endmodule // pin_sync

// ===== rtl/adc_conv_ctrl.sv
// Converter control core: conversion sequencing, done flags, result bus.
// Assumes host pins are asynchronous; analog result arrives as sample_code.
// How it works
// R1: Drive bus only when select and read low
// R2: Internal mode: track low, convert on rise
// R3: Pulse both done flags low on result
// R4: External mode: sample on rise, advance per clock
// R5: Host: first external clock within 10us
// R6: Host: keep external clock above 100kHz
// R7: External mode: flags low at 13th edge
// R8: Host holds start high until read done
// R9: Start falling mid-conversion aborts and restarts
// R10: Host keeps bus quiet 50ns before fall
// R11: Any select arrangement works
// R12: Internal mode: flags low within 900ns
// R13: Read places latched result; read rise releases
// R14: Host waits 1ms, discards first result; the bench waits 5 cycles after reset and checks it
// R15: Power-down high enters shutdown
// R16: Done flags high during shutdown
// R17: Bus drive ignores power-down state
// R18: Power-down fall starts conversion like start rise
// R19: Host discards first result after shutdown
// R20: Unipolar variant uses offset binary
// R21: Bipolar variants use two's complement
// R22: Conversion done returns high next edge or fall
// R23: Last done returns high on start fall
// R24: Conversion takes exactly 13 clock periods
// R25: Host keeps clock source select static; the bench host switches it between conversions
module adc_conv_ctrl #(
    parameter bit BIPOLAR = 1'b0  // 0 = unipolar variant, 1 = bipolar
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Host pins
    input wire adc_ctrl_pkg::host_pins_t pins,
    // Raw quantiser code, offset binary, from analog section
    input wire logic [adc_ctrl_pkg::RESULT_W-1:0] sample_code,
    // Result bus and its enable, two signals; oe low while driving
    output logic [adc_ctrl_pkg::RESULT_W-1:0] result_bus_o,
    output logic result_bus_oe_n,
    // Done flags
    output adc_ctrl_pkg::done_flags_t done,
    // Analog power-down enable toward reference and analog sections
    output logic analog_off
);
    typedef enum logic [1:0] {IDLE, TRACK, CONVERT, HOLD} state_t;

    // Done deadline counted from the synchronised start edge: the pin budget
    // less three synchroniser stages, the agreement filter and the edge detector
    localparam int INT_DONE_CYC = adc_ctrl_pkg::INT_DONE_MAX_CYC - adc_ctrl_pkg::SYNC_STAGES - 2;

    // Synchronised pin levels
    logic cs_s, rd_s, ext_clk_s, int_s, pd_s, start_s;
    logic start_prev_q, ext_prev_q, pd_prev_q; // Edge detect history
    logic start_rise, start_fall, ext_rise, pd_fall;
    state_t state_q;
    logic [3:0] period_q;          // Conversion periods elapsed
    logic [1:0] div_q;             // Internal oscillator divider
    logic tick;                    // One conversion clock period elapsed
    logic [adc_ctrl_pkg::RESULT_W-1:0] held_q;   // Held sample
    logic [adc_ctrl_pkg::RESULT_W-1:0] result_q; // Latched result

    // Output code formatting
    function automatic logic [11:0] fmt(input logic [11:0] raw);
        return BIPOLAR ? (raw ^ adc_ctrl_pkg::MID_CODE) : raw; // see R20 see R21
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    pin_sync #(.RST_VAL(1'b0)) u_start (.ref_clk(ref_clk), .arst_n(arst_n),
        .pin(pins.conv_start), .level(start_s));
    pin_sync #(.RST_VAL(1'b1)) u_cs (.ref_clk(ref_clk), .arst_n(arst_n),
        .pin(pins.sel_n), .level(cs_s));
    pin_sync #(.RST_VAL(1'b1)) u_rd (.ref_clk(ref_clk), .arst_n(arst_n),
        .pin(pins.rd_n), .level(rd_s));
    pin_sync #(.RST_VAL(1'b0)) u_ck (.ref_clk(ref_clk), .arst_n(arst_n),
        .pin(pins.ext_clk), .level(ext_clk_s));
    pin_sync #(.RST_VAL(1'b1)) u_int (.ref_clk(ref_clk), .arst_n(arst_n),
        .pin(pins.clk_src_int), .level(int_s));
    pin_sync #(.RST_VAL(1'b0)) u_pd (.ref_clk(ref_clk), .arst_n(arst_n),
        .pin(pins.power_down), .level(pd_s));

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            start_prev_q <= 1'b0;
            ext_prev_q <= 1'b0;
            pd_prev_q <= 1'b0;
        end else begin
            start_prev_q <= start_s;
            ext_prev_q <= ext_clk_s;
            pd_prev_q <= pd_s;
        end
    end
    assign start_rise = start_s & ~start_prev_q;
    assign start_fall = ~start_s & start_prev_q;
    assign ext_rise = ext_clk_s & ~ext_prev_q;
    assign pd_fall = ~pd_s & pd_prev_q; // Leaving shutdown

    // Period tick: divided oscillator or host clock edge
    assign tick = int_s ? (div_q == 2'(adc_ctrl_pkg::INT_DIV - 1)) : ext_rise; // see R4

    // ------------------------------------------------------------
    // Internal oscillator divider, restarted at each conversion
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= 2'h0;
        end else if (state_q != CONVERT || tick) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= IDLE;
            period_q <= 4'h0;
        end else if (pd_s) begin
            state_q <= IDLE; // Shutdown; see R15
            period_q <= 4'h0;
        end else if (start_rise || pd_fall) begin
            state_q <= CONVERT; // see R2 see R18
            period_q <= 4'h0;
        end else if (start_fall) begin
            state_q <= TRACK; // Abort any conversion; see R9
            period_q <= 4'h0;
        end else begin
            unique case (state_q)
                IDLE, TRACK, HOLD: ;
                CONVERT: begin
                    if (tick) begin
                        if (period_q == 4'(adc_ctrl_pkg::CONV_PERIODS - 1)) begin
                            state_q <= HOLD; // 13th period; see R24 see R7
                        end
                        period_q <= period_q + 4'h1;
                    end
                end
            endcase
        end
    end

    // Sample captured on the start edge
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            held_q <= adc_ctrl_pkg::RESULT_RST;
        end else if (start_rise || pd_fall) begin
            held_q <= sample_code; // see R4
        end
    end

    // Result latched at end of conversion
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            result_q <= adc_ctrl_pkg::RESULT_RST;
        end else if (state_q == CONVERT && tick && !pd_s && !start_fall
                     && period_q == 4'(adc_ctrl_pkg::CONV_PERIODS - 1)) begin
            result_q <= fmt(held_q);
        end
    end

    // ------------------------------------------------------------
    // Done flags
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            done <= '1;
        end else if (pd_s || start_fall || start_rise || pd_fall) begin
            done <= '1; // see R16 see R22 see R23
        end else if (state_q == CONVERT && tick
                     && period_q == 4'(adc_ctrl_pkg::CONV_PERIODS - 1)) begin
            done <= '0; // see R3 see R12
        end else if (state_q == HOLD && tick && !int_s) begin
            done.conv_done_n <= 1'b1; // Next host clock edge; see R22
        end
    end

    // ------------------------------------------------------------
    // Result bus driver, independent of power-down
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            result_bus_oe_n <= 1'b1;
            result_bus_o <= adc_ctrl_pkg::RESULT_RST;
        end else begin
            result_bus_oe_n <= cs_s | rd_s; // see R1 see R17
            result_bus_o <= result_q; // see R13
        end
    end

    // Analog power-down output
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            analog_off <= 1'b0;
        end else begin
            analog_off <= pd_s; // see R15
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Last period ticks with nothing pre-empting it
    sequence conv_end_s;
        state_q == CONVERT && tick && !pd_s && !start_fall && !start_rise && !pd_fall
            && period_q == 4'(adc_ctrl_pkg::CONV_PERIODS - 1);
    endsequence

    // Internal-mode start outside shutdown
    sequence int_start_s;
        start_rise && int_s && !pd_s;
    endsequence

    bus_release_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R1
        cs_s || rd_s |=> result_bus_oe_n)
        else $error("bus driven while deselected");
    bus_read_drive_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R13
        !cs_s && !rd_s |=> !result_bus_oe_n && result_bus_o == $past(result_q))
        else $error("bus not driving latched result");
    done_pulse_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R3
        conv_end_s |=> done == 2'b00)
        else $error("done flags not pulsed");
    shutdown_flags_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R16
        pd_s |=> done == 2'b11)
        else $error("done flag low in shutdown");
    abort_restart_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R9
        start_fall && !pd_s && !start_rise && !pd_fall |=> state_q == TRACK && done == 2'b11)
        else $error("abort not taken");
    pd_start_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R18
        pd_fall && !pd_s |=> state_q == CONVERT && period_q == 4'h0)
        else $error("power-down exit did not start");
    int_deadline_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R12
        int_start_s |-> ##[1:INT_DONE_CYC] (done == 2'b00 || pd_s || start_fall))
        else $error("internal conversion too slow");
    period_count_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R24
        state_q == HOLD |-> period_q == 4'(adc_ctrl_pkg::CONV_PERIODS))
        else $error("wrong period count");
    power_off_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R15
        $rose(pd_s) |=> analog_off)
        else $error("analog not powered down");
    last_done_clear_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // see R23
        start_fall |=> done.last_conversion_done_n)
        else $error("last done not cleared");
endmodule // adc_conv_ctrl

// ===== testbench/host_model.sv
// Host controller model: start strobe, select, read, external clock, power-down.
// Assumes the bench calls its tasks; every pin moves on a falling ref_clk edge.
module host_model (
    // Clock
    input wire logic ref_clk,
    // Pins toward the converter
    output adc_ctrl_pkg::host_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------
    // Start low tracks, clock stands still, bus released
    initial begin
        pins = '0;
        pins.sel_n = 1'b1;
        pins.rd_n = 1'b1;
        pins.clk_src_int = 1'b1;
    end

    // ------------------------------------------------------------
    // Pin tasks
    // ------------------------------------------------------------
    // Start strobe; callers only move it with the bus quiet
    task automatic set_start(input logic v);
        @(negedge ref_clk) pins.conv_start = v;
    endtask

    // Strap changed only between conversions
    task automatic set_src(input logic v);
        @(negedge ref_clk) pins.clk_src_int = v;
    endtask

    // Power-down request level
    task automatic set_pd(input logic v);
        @(negedge ref_clk) pins.power_down = v;
    endtask

    // Select and read fall together, covering the tied arrangement
    task automatic read_begin();
        @(negedge ref_clk);
        pins.sel_n = 1'b0;
        pins.rd_n = 1'b0;
    endtask

    // Read rises; select either follows or stays low until a later read_end
    task automatic read_end(input logic sel_after);
        @(negedge ref_clk);
        pins.rd_n = 1'b1;
        pins.sel_n = sel_after;
    endtask

    // First pulse at once after the start rise 5 MHz keeps the hold fresh
    task automatic ext_pulses(input int n);
        repeat (n) begin
            @(negedge ref_clk) pins.ext_clk = 1'b1;
            repeat (5) @(negedge ref_clk);
            pins.ext_clk = 1'b0;
            repeat (4) @(negedge ref_clk);
        end
    endtask
endmodule // host_model

// ===== testbench/adc_conversion_read_interface_test.sv
// Self-checking bench for the converter control core, both code variants.
// Assumes host_model drives the pins and the bench drives sample_code.
module adc_conversion_read_interface_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic ref_clk;                         // 50 MHz clock
    logic arst_n;                          // Reset, active low
    logic [11:0] sample_code;              // Raw quantiser code
    adc_ctrl_pkg::host_pins_t pins;        // Host pins
    logic [11:0] bus_u, bus_b;             // Result buses
    logic oe_u, oe_b;                      // Bus enables, low drives
    adc_ctrl_pkg::done_flags_t done_u, done_b; // Done flags, both variants
    logic off_u, off_b;                    // Analog power-down, both variants
    int bad_count = 0;                     // Mismatches
    int checks = 0;                        // Comparisons

    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    host_model host (.ref_clk(ref_clk), .pins(pins));
    adc_conv_ctrl #(.BIPOLAR(1'b0)) uut (.ref_clk(ref_clk), .arst_n(arst_n), .pins(pins),
        .sample_code(sample_code), .result_bus_o(bus_u), .result_bus_oe_n(oe_u),
        .done(done_u), .analog_off(off_u));
    // Bipolar variant shares every input; its bus, enable, flags and power-down are judged
    adc_conv_ctrl #(.BIPOLAR(1'b1)) uut_bip (.ref_clk(ref_clk), .arst_n(arst_n), .pins(pins),
        .sample_code(sample_code), .result_bus_o(bus_b), .result_bus_oe_n(oe_b),
        .done(done_b), .analog_off(off_b));

    // ------------------------------------------------------------
    // Compare and wait helpers
    // ------------------------------------------------------------
    task automatic chk_bit(input string what, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic chk_flags(input string what, input logic [1:0] e, input logic [1:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic chk_word(input string what, input logic [11:0] e, input logic [11:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    // Bounded wait for both flags low
    task automatic wait_done(input int lim);
        int n;
        n = 0;
        while (done_u !== 2'b00 && n < lim) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask

    // Bounded wait for a bus enable level; synchroniser latency is a few cycles
    task automatic wait_oe(input logic v);
        int n;
        n = 0;
        while (oe_u !== v && n < 10) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask

    // One read cycle with both code forms judged
    task automatic read_check(input logic [11:0] code, input logic sel_after);
        chk_bit("oe idle", 1'b1, oe_u);
        host.read_begin();
        wait_oe(1'b0);
        chk_bit("oe read", 1'b0, oe_u);
        chk_bit("oe bip", 1'b0, oe_b);
        chk_word("offset code", code, bus_u);
        chk_word("twos code", code ^ 12'h800, bus_b);
        host.read_end(sel_after);
        wait_oe(1'b1);
        chk_bit("oe release", 1'b1, oe_u);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Internal clock: deadline, latch at rise, flags return on start fall
    task automatic t_internal();
        sample_code = 12'h123;
        repeat (10) @(negedge ref_clk);
        host.set_start(1'b1);
        repeat (10) @(negedge ref_clk);
        sample_code = 12'hfff;                    // Late change must not leak in
        wait_done(35);                            // Last look inside 900ns of the pin rise
        chk_flags("int done", 2'b00, done_u);
        chk_flags("bip done", 2'b00, done_b);
        read_check(12'h123, 1'b1);
        host.set_start(1'b0);
        repeat (8) @(posedge ref_clk);
        #1;
        chk_flags("start fall", 2'b11, done_u);
    endtask

    // External clock: 12 edges not enough, 13th finishes, 14th lifts conversion done only
    task automatic t_external();
        host.set_src(1'b0);
        sample_code = 12'h9a5;
        repeat (10) @(negedge ref_clk);
        host.set_start(1'b1);
        host.ext_pulses(12);
        sample_code = 12'h000;                    // Well after the synchronised start edge
        chk_flags("ext 12", 2'b11, done_u);
        host.ext_pulses(1);
        chk_flags("ext 13", 2'b00, done_u);
        host.ext_pulses(1);
        chk_flags("ext 14", 2'b10, done_u);
        read_check(12'h9a5, 1'b0);
        read_check(12'h9a5, 1'b1);
        host.set_start(1'b0);
        host.set_src(1'b1);
    endtask

    // Start falls mid-conversion: no result, next one runs whole
    task automatic t_abort();
        sample_code = 12'h3c3;
        repeat (10) @(negedge ref_clk);
        host.set_start(1'b1);
        repeat (15) @(negedge ref_clk);
        host.set_start(1'b0);
        sample_code = 12'h5a5;
        repeat (60) @(negedge ref_clk);
        chk_flags("aborted", 2'b11, done_u);
        read_check(12'h9a5, 1'b1);
        host.set_start(1'b1);
        wait_done(46);
        chk_flags("restart", 2'b00, done_u);
        read_check(12'h5a5, 1'b1);
    endtask

    // Shutdown: flags high, bus still readable, leaving starts a conversion
    task automatic t_shutdown();
        host.set_pd(1'b1);
        repeat (8) @(posedge ref_clk);
        #1;
        chk_flags("pd flags", 2'b11, done_u);
        chk_bit("pd analog", 1'b1, off_u);
        chk_bit("bip analog", 1'b1, off_b);
        chk_flags("bip pd flags", 2'b11, done_b);
        read_check(12'h5a5, 1'b1);
        @(negedge ref_clk);
        sample_code = 12'h7ff;
        host.set_pd(1'b0);
        wait_done(46);
        chk_flags("pd exit", 2'b00, done_u);
        chk_bit("pd analog", 1'b0, off_u);
        read_check(12'h7ff, 1'b1);                // Discarded by real hosts
        host.set_start(1'b0);
    endtask

    // Mid-run reset during a shutdown read: outputs drop to reset levels, then recover
    task automatic t_reset();
        host.set_pd(1'b1);
        host.read_begin();
        wait_oe(1'b0);
        chk_bit("pre reset off", 1'b1, off_u);
        @(negedge ref_clk);
        arst_n = 1'b0;
        #1;
        chk_bit("reset oe", 1'b1, oe_u);
        chk_bit("reset off", 1'b0, off_u);
        chk_flags("reset flags", 2'b11, done_u);
        repeat (2) @(negedge ref_clk);
        arst_n = 1'b1;
        @(posedge ref_clk);
        #1;
        chk_bit("first edge oe", 1'b1, oe_u);
        wait_oe(1'b0);
        chk_word("reset result", adc_ctrl_pkg::RESULT_RST, bus_u);
        repeat (4) @(posedge ref_clk);
        #1;
        chk_bit("off again", 1'b1, off_u);
        host.read_end(1'b1);
        wait_oe(1'b1);
        chk_bit("reset release", 1'b1, oe_u);
        host.set_pd(1'b0);
    endtask

    // ------------------------------------------------------------
    // Verdict
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Main sequence; first conversion after reset stands for the wake-up discard
    initial begin
        arst_n = 1'b0;
        sample_code = 12'h000;
        repeat (10) @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (5) @(negedge ref_clk);
        t_internal();
        t_external();
        t_abort();
        t_shutdown();
        t_reset();
        finish_test();
    end

    // Watchdog: the run needs about 530 cycles
    initial begin
        #100us;
        bad_count++;
        finish_test();
    end
endmodule // adc_conversion_read_interface_test
